// >>> src/swpm_power_manager.sv
`timescale 1ns/1ps
// Functional notes
// [RL1] The manager is always in exactly one of Normal or Sleep, never both.
// [RL2] The manager stays powered and runs only on the low-speed oscillator tick; here all logic runs on clk_i and only the watchdog counts ticks.
// [RL3] The 10 kHz oscillator never stops; its tick is derived and never gated.
// [RL4] Fabric decides on sleep, loads the wake time, then issues the sleep command.
// [RL5] In Sleep the user wake pin or watchdog expiry wakes the device.
// [RL6] In Sleep an I2C address match or full FIFO on the wake-capable core wakes it.
// [RL7] In Sleep the core is power gated while configuration and block RAM are retained.
// [RL8] In Sleep the manager and its pins stay active to see wake events.
// [RL9] In Normal every element is enabled as the design needs.
// [RL10] Sleep is entered only on command; the first wake event returns to Normal.
module swpm_power_manager
  import swpm_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              sleep_cmd_i,
  input  wire logic [WDOG_W-1:0] wake_time_i,
  input  wire logic              wdog_en_i,
  input  wire logic              user_wake_pin_i,
  input  wire logic              i2c_addr_match_i,
  input  wire logic              i2c_fifo_full_i,
  output logic                   normal_o,
  output logic                   sleep_o,
  output logic                   core_power_en_o,
  output logic                   retain_o,
  output logic                   lf_tick_o,
  output logic [WAKE_N-1:0]      wake_cause_o,
  output logic                   wake_pulse_o
);

  // ****************************************
  // Pin synchroniser
  // ****************************************
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic [2:0] pin_raw;
  // Wake inputs come from pins and the I2C core on their own timing
  assign pin_raw = {i2c_fifo_full_i, i2c_addr_match_i, user_wake_pin_i};

  // Two stages on every asynchronous wake input; only stage two is read
  // Trade-off: two cycles of wake latency buy a settled sample
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ****************************************
  // Low-frequency tick
  // ****************************************
  logic [LF_DIV_W-1:0] div_q;
  logic [LF_DIV_W-1:0] div_d;
  logic                tick_d;
  logic                tick_q;

  // [RL3] free-running divider
  // No enable input exists, so the tick can never be stopped
  // Tick accuracy follows the system clock, not the oscillator pin
  always_comb begin
    tick_d = (div_q == LF_DIV_LAST);
    div_d  = tick_d ? DIV_RESET : div_q + 1'b1;
  end

  // Divider registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q  <= DIV_RESET;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  // ****************************************
  // Power state machine
  // ****************************************
  swpm_state_type      state_q;
  swpm_state_type      state_d;
  // Watchdog count, loaded with the command and counted down while asleep
  logic [WDOG_W-1:0]   wdog_q;
  logic [WDOG_W-1:0]   wdog_d;
  logic                wdog_en_q;
  logic                wdog_en_d;
  logic [WAKE_N-1:0]   wake_vec;
  logic [WAKE_N-1:0]   cause_q;
  logic [WAKE_N-1:0]   cause_d;
  logic                wpulse_d;
  logic                wpulse_q;
  logic                cmd_q;
  logic                cmd_d;
  logic                cmd_rise;

  // Sleep command edge; the command comes from same-clock fabric logic
  // Only a fresh rise counts, so a command left high cannot re-enter
  // sleep straight after a wake
  always_comb begin
    cmd_d    = sleep_cmd_i;
    cmd_rise = sleep_cmd_i & ~cmd_q;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  // [RL5] wake sources
  // [RL6] I2C wake sources
  // [RL8] detection keeps running while asleep
  // Levels, not edges: a source still high at entry wakes at once
  always_comb begin
    wake_vec                = WAKE_RESET;
    wake_vec[WAKE_PIN]      = pin_sync_q[0];
    wake_vec[WAKE_WDOG]     = wdog_en_q && (wdog_q == WDOG_RESET);
    wake_vec[WAKE_I2C_ADDR] = pin_sync_q[1];
    wake_vec[WAKE_I2C_FIFO] = pin_sync_q[2];
  end

  // Next-state logic for the power state, watchdog and wake record
  // [RL2] all sleep timing counts oscillator ticks only
  // The watchdog counts ticks, so the wake time is in oscillator periods
  always_comb begin
    state_d   = state_q;
    wdog_d    = wdog_q;
    wdog_en_d = wdog_en_q;
    cause_d   = cause_q;
    wpulse_d  = 1'b0;
    case (state_q)
      SWPM_NORMAL: begin
        // [RL4] parameters latched with the command
        // [RL10] sleep only on command
        // The old cause stays readable until sleep starts again
        if (cmd_rise) begin
          state_d   = SWPM_SLEEP;
          wdog_d    = wake_time_i;
          wdog_en_d = wdog_en_i;
          cause_d   = WAKE_RESET;
        end
      end
      SWPM_SLEEP: begin
        // [RL10] first wake event ends sleep
        // A wake wins over a decrement in the same cycle
        if (|wake_vec) begin
          state_d   = SWPM_NORMAL;
          cause_d   = wake_vec;
          wpulse_d  = 1'b1;
          wdog_en_d = 1'b0;
        end else if (wdog_en_q && tick_q) begin
          wdog_d = wdog_q - 1'b1;
        end
      end
      // [RL1] illegal codes fall back to Normal
      // Only an upset of the state flops can land here
      default: begin
        state_d   = SWPM_NORMAL;
        wdog_en_d = 1'b0;
      end
    endcase
  end

  // State registers only; every decision is made above
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q   <= SWPM_NORMAL;
      wdog_q    <= WDOG_RESET;
      wdog_en_q <= 1'b0;
      cause_q   <= WAKE_RESET;
      wpulse_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      wdog_q    <= wdog_d;
      wdog_en_q <= wdog_en_d;
      cause_q   <= cause_d;
      wpulse_q  <= wpulse_d;
    end
  end

  // ****************************************
  // Retention hold
  // ****************************************
  logic retain_q;
  logic retain_d;

  // [RL7] retention never released
  // Held in a flop so this output leaves a register like every other one
  always_comb begin
    retain_d = 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      retain_q <= 1'b1;
    end else begin
      retain_q <= retain_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output leaves a flop with no logic after it
  // Core power follows Normal, so the gate opens on the wake edge
  // [RL1] state flags come from the one-hot bits, so never both
  // [RL7] core gate off in Sleep, retention held
  // [RL9] full power in Normal
  always_comb begin
    normal_o        = state_q[0];
    sleep_o         = state_q[1];
    core_power_en_o = state_q[0];
    retain_o        = retain_q;
    lf_tick_o       = tick_q;
    wake_cause_o    = cause_q;
    wake_pulse_o    = wpulse_q;
  end

endmodule : swpm_power_manager

// >>> src/swpm_pkg.sv
package swpm_pkg;

  // ****************************************
  // Timing
  // ****************************************
  // Always-on oscillator rate and the system clock that samples it
  localparam int unsigned LFOSC_HZ       = 10000;
  localparam int unsigned CLK_HZ         = 40000000;
  // System clock cycles per low-frequency oscillator period
  localparam int unsigned LF_DIV_CYCLES  = CLK_HZ / LFOSC_HZ;
  localparam int unsigned LF_DIV_W       = 12;
  localparam logic [LF_DIV_W-1:0] LF_DIV_LAST = LF_DIV_W'(LF_DIV_CYCLES - 1);

  // ****************************************
  // Watchdog and reset values
  // ****************************************
  localparam int unsigned WDOG_W         = 16;
  localparam logic [WDOG_W-1:0] WDOG_RESET   = 16'h0000;
  localparam logic [LF_DIV_W-1:0] DIV_RESET  = 12'h000;

  // Wake source indices
  localparam int unsigned WAKE_PIN       = 0;
  localparam int unsigned WAKE_WDOG      = 1;
  localparam int unsigned WAKE_I2C_ADDR  = 2;
  localparam int unsigned WAKE_I2C_FIFO  = 3;
  localparam int unsigned WAKE_N         = 4;
  localparam logic [WAKE_N-1:0] WAKE_RESET = 4'h0;

  // Power states, one-hot
  typedef enum logic [1:0] {
    SWPM_NORMAL = 2'b01,
    SWPM_SLEEP  = 2'b10
  } swpm_state_type;

endpackage : swpm_pkg

// >>> test/swpm_fabric_model.sv
`timescale 1ns/1ps
module swpm_fabric_model
  import swpm_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              req_i,
  input  wire logic [WDOG_W-1:0] time_i,
  input  wire logic              en_i,
  output logic                   cmd_o,
  output logic [WDOG_W-1:0]      time_o,
  output logic                   en_o
);
  logic ld_q = 1'b0;
  initial cmd_o = 1'b0;
  initial time_o = '0;
  initial en_o = 1'b0;
  // parameters before command
  // Time and enable settle one cycle ahead, so they stand when sampled
  always @(posedge clk_i) begin
    if (req_i) begin
      time_o <= time_i;
      en_o <= en_i;
    end
    ld_q <= req_i;
    cmd_o <= ld_q;
  end
endmodule : swpm_fabric_model

// >>> test/swpm_power_manager_asserts.sv
`timescale 1ns/1ps
module swpm_power_manager_chk
  import swpm_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              sleep_cmd_i,
  input  wire logic [WDOG_W-1:0] wake_time_i,
  input  wire logic              wdog_en_i,
  input  wire logic              user_wake_pin_i,
  input  wire logic              i2c_addr_match_i,
  input  wire logic              i2c_fifo_full_i,
  input  wire logic              normal_o,
  input  wire logic              sleep_o,
  input  wire logic              core_power_en_o,
  input  wire logic              retain_o,
  input  wire logic              lf_tick_o,
  input  wire logic [WAKE_N-1:0] wake_cause_o,
  input  wire logic              wake_pulse_o
);

  // ****************************************
  // Clocking
  // ****************************************
  // One clock domain, so every property shares these
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // ****************************************
  // Tick spacing helper
  // ****************************************
  logic [LF_DIV_W-1:0] gap_q;
  logic                seen_q;

  // Cycles since the last tick; the first gap after reset is not judged
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_q  <= '0;
      seen_q <= 1'b0;
    end else if (lf_tick_o) begin
      gap_q  <= '0;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 1'b1;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  // exactly one state
  property p_one;
    normal_o != sleep_o;
  endproperty
  a_one: assert property (p_one) else $error("both or no state");
  property p_pwr;
    core_power_en_o == normal_o;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power gate wrong");
  property p_ret;
    retain_o;
  endproperty
  a_ret: assert property (p_ret) else $error("retention dropped");
  property p_tick;
    lf_tick_o |=> !lf_tick_o [*8];
  endproperty
  a_tick: assert property (p_tick) else $error("tick too close");
  property p_gap;
    lf_tick_o && seen_q |-> gap_q == LF_DIV_LAST;
  endproperty
  a_gap: assert property (p_gap) else $error("tick period wrong");
  property p_ent;
    $rose(sleep_o) |-> $past(sleep_cmd_i);
  endproperty
  a_ent: assert property (p_ent) else $error("sleep without command");
  property p_pin;
    sleep_o && user_wake_pin_i |-> ##[1:4] wake_pulse_o;
  endproperty
  a_pin: assert property (p_pin) else $error("pin did not wake");
  property p_i2c;
    sleep_o && (i2c_addr_match_i || i2c_fifo_full_i) |-> ##[1:4] wake_pulse_o;
  endproperty
  a_i2c: assert property (p_i2c) else $error("i2c did not wake");
  property p_wp;
    wake_pulse_o |-> normal_o && $past(sleep_o) && wake_cause_o != 0;
  endproperty
  a_wp: assert property (p_wp) else $error("bad wake pulse");

  // ****************************************
  // Coverage
  // ****************************************
  c_sleep: cover property ($rose(sleep_o));
  c_pin: cover property (wake_pulse_o && wake_cause_o[WAKE_PIN]);
  c_wdog: cover property (wake_pulse_o && wake_cause_o[WAKE_WDOG]);
  c_i2c: cover property (wake_pulse_o && wake_cause_o[WAKE_I2C_FIFO]);
endmodule : swpm_power_manager_chk
bind swpm_power_manager swpm_power_manager_chk u_swpm_power_manager_chk (.*);

// >>> test/test_swpm_power_manager.sv
`timescale 1ns/1ps
module test_swpm_power_manager
  import swpm_pkg::*;
;
  logic clk_i = 0, rst_b_i = 0, req = 0, en = 0, pin = 0, adr = 0, ful = 0;
  logic [WDOG_W-1:0] tm = '0, wt;
  logic cmd, wen, nrm, slp, pwr, ret, tick, wp;
  logic [WAKE_N-1:0] cause;
  int n_fail = 0, comparisons = 0;
  always #12.5 clk_i = ~clk_i;
  swpm_fabric_model u_swpm_fabric_model (.clk_i, .req_i(req), .time_i(tm), .en_i(en),
    .cmd_o(cmd), .time_o(wt), .en_o(wen));
  swpm_power_manager u_swpm_power_manager (.clk_i, .rst_b_i, .sleep_cmd_i(cmd),
    .wake_time_i(wt), .wdog_en_i(wen), .user_wake_pin_i(pin), .i2c_addr_match_i(adr),
    .i2c_fifo_full_i(ful), .normal_o(nrm), .sleep_o(slp), .core_power_en_o(pwr),
    .retain_o(ret), .lf_tick_o(tick), .wake_cause_o(cause), .wake_pulse_o(wp));
  task chk(input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task report_and_stop;
    $display("fails %0d of %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // Command through the fabric model, then sleep must stand
  task go(input logic [15:0] t, input logic e);
    @(negedge clk_i);
    {tm, en, req} = {t, e, 1'b1};
    @(negedge clk_i);
    req = 0;
    repeat (3) @(negedge clk_i);
    chk(slp, 1);
    chk(nrm, 0);
    chk({pwr, ret}, 16'h1);
    chk(cause, 0);
  endtask : go
  // Wait for the wake pulse, then check it stands one cycle only
  task wake(input int i);
    for (int k = 0; k < 9000 && wp !== 1'b1; k++) @(negedge clk_i);
    chk(wp, 1);
    chk({nrm, slp}, 16'h2);
    chk(pwr, 1);
    chk(cause, 16'h1 << i);
    @(negedge clk_i);
    chk(wp, 0);
    chk(cause, 16'h1 << i);
  endtask : wake
  // Each outside source in turn; a second command while asleep is ignored
  task t_ext;
    for (int i = 0; i < WAKE_N; i++) if (i != WAKE_WDOG) begin
      go(16'h0000, 1'b0);
      go(16'h0000, 1'b0);
      {pin, adr, ful} = {i == WAKE_PIN, i == WAKE_I2C_ADDR, i == WAKE_I2C_FIFO};
      wake(i);
      {pin, adr, ful} = 3'h0;
      repeat (4) @(negedge clk_i);
    end
    $display("t_ext done");
  endtask : t_ext
  task t_wdog;
    go(16'h0001, 1'b1);
    wake(WAKE_WDOG);
    $display("t_wdog done");
  endtask : t_wdog
  // Reset in mid-sleep returns to Normal at once, and no sleep follows
  task t_rst;
    go(16'h0000, 1'b0);
    rst_b_i = 0;
    @(negedge clk_i);
    chk({nrm, slp, pwr, ret}, 16'hb);
    chk({cause, wp, tick}, 16'h0);
    rst_b_i = 1;
    repeat (2) @(negedge clk_i);
    chk({nrm, slp, wp}, 16'h4);
    $display("t_rst done");
  endtask : t_rst
  // Tick spacing equals the divider length and the tick is one cycle wide
  task t_tick;
    int n;
    n = 0;
    for (int k = 0; k < 5000 && tick !== 1'b1; k++) @(negedge clk_i);
    chk(tick, 1);
    do begin
      @(negedge clk_i);
      n++;
      if (n == 1) chk(tick, 0);
    end while (tick !== 1'b1 && n < 5000);
    chk(16'(n), 16'(LF_DIV_CYCLES));
    $display("t_tick done");
  endtask : t_tick
  // Outputs while reset is held, then release
  task t_reset;
    repeat (16) @(negedge clk_i);
    chk({nrm, slp, pwr, ret}, 16'hb);
    chk({cause, wp, tick}, 16'h0);
    rst_b_i = 1;
    $display("t_reset done");
  endtask : t_reset
  // Tests take about three divider periods; five leave margin
  initial begin
    repeat (5 * LF_DIV_CYCLES) @(negedge clk_i);
    n_fail++;
    report_and_stop;
  end
  initial begin
    t_reset;
    t_ext;
    t_wdog;
    t_rst;
    t_tick;
    report_and_stop;
  end
endmodule : test_swpm_power_manager
